/* lp_tia_regs_pkg.sv */
`default_nettype none
package lp_tia_regs_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam logic [15:0] LOOP_SWITCH_CONFIG_OFFSET = 16'h20E4;
  localparam logic [15:0] TIA_CONTROL_CHANNEL_ZERO_OFFSET = 16'h20EC;

  // ************************************************************
  // Reset values and writable masks
  // ************************************************************
  localparam logic [31:0] LOOP_SWITCH_CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] TIA_CONTROL_CHANNEL_ZERO_RESET = 32'h00000003;
  localparam logic [31:0] LOOP_SWITCH_CONFIG_WMASK = 32'h0000FFFF;
  localparam logic [31:0] TIA_CONTROL_CHANNEL_ZERO_WMASK = 32'h0000FFFF;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned LOOP_SWITCH_LSB = 0;
  localparam int unsigned LOOP_SWITCH_COUNT = 14;
  localparam int unsigned EXTERNAL_GAIN_PATH_SWITCH_BIT = 9;
  localparam int unsigned RECALIBRATION_SWITCH_BIT = 15;
  localparam int unsigned FILTER_RESISTOR_SELECT_LSB = 13;
  localparam int unsigned FILTER_RESISTOR_SELECT_W = 3;
  localparam int unsigned LOAD_RESISTOR_SELECT_LSB = 10;
  localparam int unsigned LOAD_RESISTOR_SELECT_W = 3;
  localparam int unsigned GAIN_RESISTOR_SELECT_LSB = 5;
  localparam int unsigned GAIN_RESISTOR_SELECT_W = 5;
  localparam int unsigned CONTROL_LOW_W = 5;

  // ************************************************************
  // Filter and gain resistor select codes
  // ************************************************************
  localparam logic [2:0] FILTER_CODE_DISCONNECT = 3'h0;
  localparam logic [2:0] FILTER_CODE_BYPASS = 3'h1;
  localparam logic [2:0] FILTER_CODE_ONE_MEGAOHM = 3'h7;
  localparam logic [4:0] GAIN_CODE_DETACHED = 5'h00;

  // ************************************************************
  // Bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

/* lp_tia_switch_and_filter_regs.sv */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lp_tia_switch_and_filter_regs #(
  parameter int unsigned ADDR_W = lp_tia_regs_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [13:0] loop_switch_close,
  output logic recalibration_switch_path_switch_close,
  output logic [2:0] filter_resistor_select,
  output logic filter_pin_connect,
  output logic filter_bypass,
  output logic filter_one_megaohm,
  output logic [2:0] load_resistor_select,
  output logic [4:0] gain_resistor_select,
  output logic [4:0] control_low_bits,
  output logic external_gain_mode
);

  // ************************************************************
  // Storage
  // ************************************************************
  // Full words kept; the write mask holds bits 31:16 at zero
  logic [31:0] switch_cfg_q;
  logic [31:0] switch_cfg_d;
  logic [31:0] tia_ctrl_q;
  logic [31:0] tia_ctrl_d;

  // Write channel holding state; address and data may come apart
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Registered decode of the analog controls
  logic [13:0] loop_switch_q;
  logic recalibration_switch_q;
  logic [2:0] filter_sel_q;
  logic filter_connect_q;
  logic filter_bypass_q;
  logic filter_mega_q;
  logic [2:0] load_sel_q;
  logic [4:0] gain_sel_q;
  logic [4:0] ctrl_low_q;
  logic ext_gain_q;

  // ************************************************************
  // Byte-lane merge
  // ************************************************************
  // Only lanes with their strobe set change; mask keeps reserved bits 0
  // A zero strobe leaves the word untouched yet still answers OKAY
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb,
    input logic [31:0] wmask
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & wmask;
  endfunction

  // ************************************************************
  // Write channel
  // ************************************************************
  // Ready drops while a beat is held or a response waits
  // Holding each beat lets the master offer address and data in
  // either order; protection bits are ignored, every access is
  // treated alike
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_full_q || aw_take;
  wire w_have = w_full_q || w_take;
  wire do_write = aw_have && w_have && !bvalid_q;
  wire [ADDR_W-1:0] wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_full_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_full_q ? w_strb_q : s_axi_wstrb;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Word-aligned address decode, low two bits ignored
  wire wr_word_sw = wr_addr[ADDR_W-1:2] ==
    lp_tia_regs_pkg::LOOP_SWITCH_CONFIG_OFFSET[ADDR_W-1:2];
  wire wr_word_ctl = wr_addr[ADDR_W-1:2] ==
    lp_tia_regs_pkg::TIA_CONTROL_CHANNEL_ZERO_OFFSET[ADDR_W-1:2];
  wire wr_hit_sw = do_write && wr_word_sw;
  wire wr_hit_ctl = do_write && wr_word_ctl;
  wire wr_mapped = wr_word_sw || wr_word_ctl;

  // Next register values
  assign switch_cfg_d = wr_hit_sw ? merge_lanes(switch_cfg_q, wr_data,
    wr_strb, lp_tia_regs_pkg::LOOP_SWITCH_CONFIG_WMASK) : switch_cfg_q;
  assign tia_ctrl_d = wr_hit_ctl ? merge_lanes(tia_ctrl_q, wr_data,
    wr_strb, lp_tia_regs_pkg::TIA_CONTROL_CHANNEL_ZERO_WMASK) : tia_ctrl_q;

  // Address holding buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  // Data holding buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (w_take) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // Write response; unmapped words answer with an error
  // Raised only once both beats are in hand, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= lp_tia_regs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? lp_tia_regs_pkg::RESP_OKAY :
        lp_tia_regs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset leaves every switch open and control at its reset word
  // Writes land one edge after both beats are in hand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_cfg_q <= lp_tia_regs_pkg::LOOP_SWITCH_CONFIG_RESET;
      tia_ctrl_q <= lp_tia_regs_pkg::TIA_CONTROL_CHANNEL_ZERO_RESET;
    end else begin
      switch_cfg_q <= switch_cfg_d;
      tia_ctrl_q <= tia_ctrl_d;
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  // Read decode; a word outside the map reads zero with an error
  // The word is captured at the take, so a write landing in the
  // same cycle shows only on the next read
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_word_sw = s_axi_araddr[ADDR_W-1:2] ==
    lp_tia_regs_pkg::LOOP_SWITCH_CONFIG_OFFSET[ADDR_W-1:2];
  wire rd_word_ctl = s_axi_araddr[ADDR_W-1:2] ==
    lp_tia_regs_pkg::TIA_CONTROL_CHANNEL_ZERO_OFFSET[ADDR_W-1:2];
  wire [31:0] rd_mux = rd_word_sw ? switch_cfg_q :
    rd_word_ctl ? tia_ctrl_q : 32'h00000000;
  wire [1:0] rd_resp = (rd_word_sw || rd_word_ctl) ?
    lp_tia_regs_pkg::RESP_OKAY : lp_tia_regs_pkg::RESP_SLVERR;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // One read in flight; data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= lp_tia_regs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Analog control decode
  // ************************************************************
  // Field slices of the stored words
  wire [2:0] filter_code =
    tia_ctrl_q[lp_tia_regs_pkg::FILTER_RESISTOR_SELECT_LSB
    +: lp_tia_regs_pkg::FILTER_RESISTOR_SELECT_W];
  wire [4:0] gain_code = tia_ctrl_q[lp_tia_regs_pkg::GAIN_RESISTOR_SELECT_LSB
    +: lp_tia_regs_pkg::GAIN_RESISTOR_SELECT_W];
  wire [2:0] load_code = tia_ctrl_q[lp_tia_regs_pkg::LOAD_RESISTOR_SELECT_LSB
    +: lp_tia_regs_pkg::LOAD_RESISTOR_SELECT_W];
  wire [13:0] switch_bits = switch_cfg_q[lp_tia_regs_pkg::LOOP_SWITCH_LSB
    +: lp_tia_regs_pkg::LOOP_SWITCH_COUNT];
  wire recalibration_switch_bit = switch_cfg_q[lp_tia_regs_pkg::RECALIBRATION_SWITCH_BIT];
  // Disconnect removes both pin and capacitor from the output
  wire filter_connect_d = filter_code !=
    lp_tia_regs_pkg::FILTER_CODE_DISCONNECT;
  wire filter_bypass_d = filter_code ==
    lp_tia_regs_pkg::FILTER_CODE_BYPASS;
  wire filter_mega_d = filter_code ==
    lp_tia_regs_pkg::FILTER_CODE_ONE_MEGAOHM;
  // Flags the software recipe for an external gain resistor
  wire ext_gain_d = (gain_code == lp_tia_regs_pkg::GAIN_CODE_DETACHED) &&
    switch_cfg_q[lp_tia_regs_pkg::EXTERNAL_GAIN_PATH_SWITCH_BIT];

  // Registered so the analog side sees glitch-free levels; one cycle lag
  // Reset levels mirror the stored reset words, so the pins agree
  // with what a read returns out of reset, and trail each write by a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_switch_q <= 14'h0000;
      recalibration_switch_q <= 1'b0;
      filter_sel_q <= lp_tia_regs_pkg::FILTER_CODE_DISCONNECT;
      filter_connect_q <= 1'b0;
      filter_bypass_q <= 1'b0;
      filter_mega_q <= 1'b0;
      load_sel_q <= 3'h0;
      gain_sel_q <= 5'h00;
      ctrl_low_q <= lp_tia_regs_pkg::TIA_CONTROL_CHANNEL_ZERO_RESET[4:0];
      ext_gain_q <= 1'b0;
    end else begin
      loop_switch_q <= switch_bits;
      recalibration_switch_q <= recalibration_switch_bit;
      filter_sel_q <= filter_code;
      filter_connect_q <= filter_connect_d;
      filter_bypass_q <= filter_bypass_d;
      filter_mega_q <= filter_mega_d;
      load_sel_q <= load_code;
      gain_sel_q <= gain_code;
      ctrl_low_q <= tia_ctrl_q[lp_tia_regs_pkg::CONTROL_LOW_W-1:0];
      ext_gain_q <= ext_gain_d;
    end
  end

  // Output pins
  // Every pin comes straight from a flop
  assign loop_switch_close = loop_switch_q;
  assign recalibration_switch_path_switch_close = recalibration_switch_q;
  assign filter_resistor_select = filter_sel_q;
  assign filter_pin_connect = filter_connect_q;
  assign filter_bypass = filter_bypass_q;
  assign filter_one_megaohm = filter_mega_q;
  assign load_resistor_select = load_sel_q;
  assign gain_resistor_select = gain_sel_q;
  assign control_low_bits = ctrl_low_q;
  assign external_gain_mode = ext_gain_q;

endmodule
`default_nettype wire

/* lp_tia_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module lp_tia_regs_checker #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [13:0] loop_switch_close,
  input wire logic recalibration_switch_path_switch_close,
  input wire logic [2:0] filter_resistor_select,
  input wire logic filter_pin_connect,
  input wire logic filter_bypass,
  input wire logic filter_one_megaohm,
  input wire logic [4:0] control_low_bits
);
  // ************************************************************
  // Write decode
  // ************************************************************
  // Only same-cycle address and data takes are tracked, as the bench issues
  wire logic take_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  wire logic full_w = take_w && s_axi_wstrb == 4'hF;
  wire logic hit_sw = s_axi_awaddr[15:2] == 14'h839;
  wire logic hit_ct = s_axi_awaddr[15:2] == 14'h83B;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ************************************************************
  // Properties
  // ************************************************************
  map_okay_a: assert property (
    take_w && (hit_sw || hit_ct) |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("mapped write answer wrong");
  unmap_err_a: assert property (
    take_w && !hit_sw && !hit_ct |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write answer wrong");
  switch_update_a: assert property (
    full_w && hit_sw |=> ##1 loop_switch_close == $past(s_axi_wdata[13:0], 2))
    else $error("loop switches do not follow write");
  recalibration_switch_update_a: assert property (
    full_w && hit_sw |=> ##1
      recalibration_switch_path_switch_close == $past(s_axi_wdata[15], 2))
    else $error("recalibration_switch switch does not follow write");
  filter_update_a: assert property (
    full_w && hit_ct |=> ##1
      filter_resistor_select == $past(s_axi_wdata[15:13], 2))
    else $error("filter select does not follow write");
  filter_disc_a: assert property (
    filter_pin_connect == (filter_resistor_select != 3'h0))
    else $error("filter connect wrong for code");
  filter_bypass_a: assert property (
    filter_bypass == (filter_resistor_select == 3'h1))
    else $error("filter bypass wrong for code");
  filter_meg_a: assert property (
    filter_one_megaohm == (filter_resistor_select == 3'h7))
    else $error("one megaohm select wrong for code");
  reset_val_a: assert property (
    $rose(aresetn) |-> loop_switch_close == 14'h0 && !recalibration_switch_path_switch_close
      && control_low_bits == 5'h03)
    else $error("outputs not at reset values");
endmodule

bind lp_tia_switch_and_filter_regs
  lp_tia_regs_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .loop_switch_close, .recalibration_switch_path_switch_close,
  .filter_resistor_select, .filter_pin_connect, .filter_bypass,
  .filter_one_megaohm, .control_low_bits
);
`default_nettype wire

/* lp_tia_switch_and_filter_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module lp_tia_switch_and_filter_regs_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sw_m, ct_m, d;
  logic [3:0] s_axi_wstrb = 4'h0, s;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, recalibration_switch_path_switch_close, filter_pin_connect;
  logic filter_bypass, filter_one_megaohm, external_gain_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] loop_switch_close;
  logic [2:0] filter_resistor_select, load_resistor_select;
  logic [4:0] gain_resistor_select, control_low_bits;
  logic [33:0] notes[$];
  logic [33:0] note;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h5CEEA3E4;

  lp_tia_switch_and_filter_regs dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .loop_switch_close, .recalibration_switch_path_switch_close, .filter_resistor_select,
    .filter_pin_connect, .filter_bypass, .filter_one_megaohm,
    .load_resistor_select, .gain_resistor_select, .control_low_bits,
    .external_gain_mode
  );

  // ************************************************************
  // Clock and answer watcher
  // ************************************************************
  initial begin
    forever #2 aclk = ~aclk;
  end
  // Sampled mid-cycle so the handshake values are settled
  always @(negedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      note = notes.pop_front();
      if (s_axi_bvalid) ck("bresp", note, {s_axi_bresp, 32'h0});
      else ck("rdata", note, {s_axi_rresp, s_axi_rdata});
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic ck(input string nm, input logic [33:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  function automatic logic [31:0] mg(input logic [31:0] o, n, input [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o & 32'h0000FFFF;
  endfunction
  // One transfer at a time; ready is sampled mid-cycle, valid released at the edge
  task automatic xf(input bit w, input logic [15:0] a, input logic [31:0] v,
    input logic [3:0] b, input logic [33:0] e);
    logic ta, tw, tr, dn;
    int n;
    notes.push_back(e);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= b;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    n = 0;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      n++;
    end while (!dn && n < 40);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (!dn) begin
      $display("[FAIL] bus answer expected 1 seen 0");
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic outs;
    logic [2:0] c;
    c = ct_m[15:13];
    @(negedge aclk);
    ck("switches", 34'({recalibration_switch_path_switch_close,
      loop_switch_close}), 34'({sw_m[15], sw_m[13:0]}));
    ck("control", 34'({filter_resistor_select,
      filter_pin_connect, filter_bypass, filter_one_megaohm,
      load_resistor_select, gain_resistor_select, control_low_bits}),
      34'({c, c != 3'h0, c == 3'h1, c == 3'h7, ct_m[12:0]}));
    ck("external gain", 34'(external_gain_mode),
      34'(ct_m[9:5] == 5'h00 && sw_m[9]));
    @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    sw_m = 32'h0;
    ct_m = 32'h3;
    xf(0, 16'h20E4, 32'h0, 4'h0, 34'h0);
    xf(0, 16'h20EC, 32'h0, 4'h0, 34'h3);
    outs();
    $display("test reset values done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 32'hFFFFFFFF : $random(seed);
      s = i == 0 ? 4'hF : 4'($random(seed));
      sw_m = mg(sw_m, d, s);
      xf(1, 16'h20E4, d, s, 34'h0);
      xf(0, 16'h20E4, 32'h0, 4'h0, {2'h0, sw_m});
      d = $random(seed);
      d[15:13] = 3'(i);
      ct_m = mg(ct_m, d, 4'hF);
      xf(1, 16'h20EC, d, 4'hF, 34'h0);
      xf(0, 16'h20EC, 32'h0, 4'h0, {2'h0, ct_m});
      outs();
    end
    $display("test switch and filter writes done");
    // Hole between the two registers answers an error and changes nothing
    xf(1, 16'h20E8, 32'hFFFFFFFF, 4'hF, {2'h2, 32'h0});
    xf(0, 16'h20E8, 32'h0, 4'h0, {2'h2, 32'h0});
    xf(0, 16'h20E4, 32'h0, 4'h0, {2'h0, sw_m});
    outs();
    $display("test unmapped access done");
    // External gain recipe: internal gain detached, path switch closed
    sw_m = 32'h00000200;
    ct_m = 32'h0000E003;
    xf(1, 16'h20E4, sw_m, 4'hF, 34'h0);
    xf(1, 16'h20EC, ct_m, 4'hF, 34'h0);
    outs();
    // Internal gain back in use, so the recipe no longer holds
    ct_m = 32'h0000E023;
    xf(1, 16'h20EC, ct_m, 4'hF, 34'h0);
    outs();
    $display("test external gain done");
    do_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
